// File: common/fdc_support_pkg.sv
`default_nettype none
package fdc_support_pkg;
   // Processor I/O map
   localparam logic [15:0] STATUS_ADDR = 16'hfc08;
   localparam logic [15:0] DATA_ADDR = 16'hfc09;
   // controller_status field positions
   localparam int RFM_BIT = 7;
   localparam int DIR_BIT = 6;
   localparam int NONDMA_BIT = 5;
   localparam int BUSY_BIT = 4;
   // Result byte 1 overrun flag position
   localparam int OVERRUN_BIT = 4;
   localparam int ABORT_BIT = 6;
   localparam logic [7:0] IDLE_READ_VALUE = 8'hff;
   localparam int MAX_RESULTS = 7;
   localparam int MAX_CMD_BYTES = 9;
   // Command opcodes (low five bits)
   localparam logic [4:0] OP_SPECIFY = 5'h03;
   localparam logic [4:0] OP_WRITE = 5'h05;
   localparam logic [4:0] OP_READ = 5'h06;
   localparam logic [4:0] OP_RECAL = 5'h07;
   localparam logic [4:0] OP_SENSE = 5'h08;
   localparam logic [4:0] OP_SEEK = 5'h0f;
   // Clock rates
   localparam longint CLK_HZ = 10_000_000;
   localparam longint MASTER_HZ = 8_000_000;
   localparam longint CTRL_HZ = 4_000_000;
   // Phase accumulator producing master ticks from mclk
   localparam logic [3:0] NCO_STEP = 4'(MASTER_HZ / 1_000_000);
   localparam logic [3:0] NCO_MOD = 4'(CLK_HZ / 1_000_000);
   // DMA service window, longest time, counted in controller ticks
   localparam longint DMA_WINDOW_NS = 32_000;
   localparam logic [7:0] DMA_WINDOW_TICKS =
      8'((DMA_WINDOW_NS * CTRL_HZ) / 1_000_000_000);
   // Motor hold time
   localparam longint MOTOR_HOLD_MS = 2_000;
   localparam longint MOTOR_HOLD_CYCLES = (MOTOR_HOLD_MS * CLK_HZ) / 1_000;
   localparam int SECTOR_BYTES = 512;

   typedef enum logic [1:0] {
      PH_COMMAND,
      PH_EXECUTE,
      PH_RESULT
   } phase_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [15:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic registerSelectLine;
      logic writeStrobe;
      logic readStrobe;
   } reg_sel_t;
endpackage
`default_nettype wire

// File: hw/write_clock_gen.sv
`default_nettype none
module write_clock_gen (
   input wire logic mclk,
   input wire logic rst,
   output logic masterTick,
   output logic ctrlTick,
   output logic div4Tap,
   output logic div8Tap,
   output logic div16Tap,
   output logic slowWriteTick
);
   logic [3:0] ncoAcc_q;
   logic [4:0] ncoSum;
   logic [3:0] divCnt_q;

   // Eight master ticks in every ten mclk cycles
   assign ncoSum = {1'b0, ncoAcc_q} + {1'b0, fdc_support_pkg::NCO_STEP};
   assign masterTick = ncoSum >= {1'b0, fdc_support_pkg::NCO_MOD};

   always_ff @(posedge mclk) begin
      if (rst) begin
         ncoAcc_q <= 4'h0;
      end else if (masterTick) begin
         ncoAcc_q <= 4'(ncoSum - {1'b0, fdc_support_pkg::NCO_MOD});
      end else begin
         ncoAcc_q <= ncoSum[3:0];
      end
   end

   // Divider counter on the master clock
   always_ff @(posedge mclk) begin
      if (rst) begin
         divCnt_q <= 4'h0;
      end else if (masterTick) begin
         divCnt_q <= divCnt_q + 4'h1;
      end
   end

   assign ctrlTick = masterTick & divCnt_q[0];
   assign div4Tap = divCnt_q[1];
   assign div8Tap = divCnt_q[2];
   assign div16Tap = divCnt_q[3];

   always_ff @(posedge mclk) begin
      if (rst) begin
         slowWriteTick <= 1'b0;
      end else begin
         slowWriteTick <= div4Tap & div8Tap & div16Tap;
      end
   end
endmodule
`default_nettype wire

// File: hw/floppy_ctrl_support_logic.sv
// Functional notes
// - Up to seven result bytes, count set by the executed command.
// - Result bytes leave one per data port read, each read advancing.
// - After the last result byte the block accepts a new command.
// - Reading the final result arms a two second motor hold timer.
// - Status byte is written only internally, read at FC08.
// - Commands and parameters enter through the data port at FC09.
// - Decoder makes select, write and read strobes from both addresses.
// - Each sixteen bit processor word carries one controller byte on one lane.
// - A 4 MHz tick paces only the DMA service watchdog.
// - Unserviced DMA byte within 32 us sets overrun and aborts command.
// - 8 MHz master gives precomp clock, 4 MHz tick and write taps.
// - Divider yields master divided by 4, 8 and 16.
// - ANDed taps form a 0.5 MHz write tick, 250 ns wide.
// - Status bit 7 shows the data port ready for a transfer.
// - Status bit 6 shows direction, one for processor reads.
// - Pre-shift selects choose early, normal or late write data.
`default_nettype none
module floppy_ctrl_support_logic #(
   parameter int SECTOR_BYTES = fdc_support_pkg::SECTOR_BYTES,
   parameter longint MOTOR_HOLD_CYCLES = fdc_support_pkg::MOTOR_HOLD_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire fdc_support_pkg::io_req_t ioReq,
   output logic [15:0] ioRdata,
   output logic ioRdValid,
   output fdc_support_pkg::reg_sel_t regSel,
   output logic dmaReq,
   input wire logic dmaAck,
   output logic motorOn,
   input wire logic writeDataRaw,
   input wire logic preShiftSelLow,
   input wire logic preShiftSelHigh,
   output logic writeData,
   output logic slowWriteTick,
   output logic div4Tap,
   output logic div8Tap,
   output logic div16Tap
);
   initial begin
      if (SECTOR_BYTES < 1 || SECTOR_BYTES > 65536) begin
         $error("SECTOR_BYTES out of range");
      end
      if (MOTOR_HOLD_CYCLES < 1 || MOTOR_HOLD_CYCLES >= (64'd1 << 32)) begin
         $error("MOTOR_HOLD_CYCLES out of range");
      end
   end

   fdc_support_pkg::phase_t phase_q;
   logic [7:0] cmdBytes_q [fdc_support_pkg::MAX_CMD_BYTES];
   logic [7:0] results_q [fdc_support_pkg::MAX_RESULTS];
   logic [3:0] byteIdx_q;
   logic [3:0] cmdLen;
   logic [3:0] resLen;
   logic [4:0] opcode;
   logic [4:0] lenOp;
   logic [7:0] dmaWait_q;
   logic [16:0] xferCnt_q;
   logic overrun_q;
   logic [31:0] holdCnt_q;
   logic masterTick;
   logic ctrlTick;
   logic statusHit;
   logic dataHit;
   logic rfm;
   logic dir;
   logic [7:0] statusByte;
   logic [7:0] wrByte;
   logic cmdWrite;
   logic resRead;
   logic [1:0] wrSync_q;
   logic [1:0] selSyncA_q;
   logic [1:0] selSyncB_q;
   logic [7:0] shift_q;
   logic [3:0] muxIn;

   write_clock_gen clocks (
      .mclk(mclk),
      .rst(rst),
      .masterTick(masterTick),
      .ctrlTick(ctrlTick),
      .div4Tap(div4Tap),
      .div8Tap(div8Tap),
      .div16Tap(div16Tap),
      .slowWriteTick(slowWriteTick)
   );

   // Address decoder
   always_comb begin
      statusHit = 1'b0;
      dataHit = 1'b0;
      if (ioReq.addr == fdc_support_pkg::STATUS_ADDR) begin
         statusHit = 1'b1;
      end else if (ioReq.addr == fdc_support_pkg::DATA_ADDR) begin
         dataHit = 1'b1;
      end
   end
   assign regSel.registerSelectLine = dataHit;
   assign regSel.writeStrobe = ioReq.wr & (statusHit | dataHit);
   assign regSel.readStrobe = ioReq.rd & (statusHit | dataHit);

   // Odd data port rides the high byte lane
   assign wrByte = ioReq.wdata[15:8];

   // Status byte, built only from internal state
   assign rfm = phase_q != fdc_support_pkg::PH_EXECUTE;
   assign dir = phase_q == fdc_support_pkg::PH_RESULT;
   always_comb begin
      statusByte = 8'h00;
      statusByte[fdc_support_pkg::RFM_BIT] = rfm;
      statusByte[fdc_support_pkg::DIR_BIT] = dir;
      statusByte[fdc_support_pkg::NONDMA_BIT] = 1'b0;
      statusByte[fdc_support_pkg::BUSY_BIT] =
         phase_q != fdc_support_pkg::PH_COMMAND;
   end

   // Writes only when ready and direction is inward
   assign cmdWrite = regSel.writeStrobe & dataHit & rfm & ~dir;
   assign resRead = regSel.readStrobe & dataHit & rfm & dir;

   // Lengths per command
   assign opcode = cmdBytes_q[0][4:0];
   // Opcode byte not yet stored while it is written
   assign lenOp = (phase_q == fdc_support_pkg::PH_COMMAND &&
      byteIdx_q == 4'h0) ? wrByte[4:0] : opcode;
   always_comb begin
      case (lenOp)
         fdc_support_pkg::OP_READ,
         fdc_support_pkg::OP_WRITE: begin
            cmdLen = 4'd9;
            resLen = 4'd7;
         end
         fdc_support_pkg::OP_SPECIFY,
         fdc_support_pkg::OP_SEEK: begin
            cmdLen = 4'd3;
            resLen = 4'd0;
         end
         fdc_support_pkg::OP_RECAL: begin
            cmdLen = 4'd2;
            resLen = 4'd0;
         end
         fdc_support_pkg::OP_SENSE: begin
            cmdLen = 4'd1;
            resLen = 4'd2;
         end
         default: begin
            cmdLen = 4'd1;
            resLen = 4'd1;
         end
      endcase
   end

   // Command, execution and result sequencing
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_q <= fdc_support_pkg::PH_COMMAND;
         byteIdx_q <= 4'h0;
      end else begin
         case (phase_q)
            fdc_support_pkg::PH_COMMAND: begin
               if (cmdWrite) begin
                  if (byteIdx_q != 4'h0 && byteIdx_q + 4'h1 >= cmdLen) begin
                     byteIdx_q <= 4'h0;
                     phase_q <= fdc_support_pkg::PH_EXECUTE;
                  end else if (byteIdx_q == 4'h0 && cmdLen == 4'd1 &&
                        wrByte[4:0] != fdc_support_pkg::OP_SENSE) begin
                     phase_q <= fdc_support_pkg::PH_RESULT;
                  end else if (byteIdx_q == 4'h0 &&
                        wrByte[4:0] == fdc_support_pkg::OP_SENSE) begin
                     phase_q <= fdc_support_pkg::PH_RESULT;
                  end else begin
                     byteIdx_q <= byteIdx_q + 4'h1;
                  end
               end
            end
            fdc_support_pkg::PH_EXECUTE: begin
               if (opcode != fdc_support_pkg::OP_READ &&
                     opcode != fdc_support_pkg::OP_WRITE) begin
                  phase_q <= resLen == 4'd0 ? fdc_support_pkg::PH_COMMAND
                        : fdc_support_pkg::PH_RESULT;
               end else if (ctrlTick &&
                     dmaWait_q >= fdc_support_pkg::DMA_WINDOW_TICKS - 8'd1 &&
                     !dmaAck) begin
                  phase_q <= fdc_support_pkg::PH_RESULT;
               end else if (dmaAck &&
                     xferCnt_q == 17'(SECTOR_BYTES - 1)) begin
                  phase_q <= fdc_support_pkg::PH_RESULT;
               end
            end
            default: begin
               if (resRead) begin
                  if (byteIdx_q + 4'h1 >= resLen) begin
                     byteIdx_q <= 4'h0;
                     phase_q <= fdc_support_pkg::PH_COMMAND;
                  end else begin
                     byteIdx_q <= byteIdx_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Command byte store
   always_ff @(posedge mclk) begin
      if (cmdWrite && byteIdx_q < 4'(fdc_support_pkg::MAX_CMD_BYTES)) begin
         cmdBytes_q[byteIdx_q] <= wrByte;
      end
   end

   // DMA service watchdog on controller ticks
   assign dmaReq = phase_q == fdc_support_pkg::PH_EXECUTE &&
      (opcode == fdc_support_pkg::OP_READ ||
      opcode == fdc_support_pkg::OP_WRITE);
   always_ff @(posedge mclk) begin
      if (rst || phase_q != fdc_support_pkg::PH_EXECUTE) begin
         dmaWait_q <= 8'h00;
         xferCnt_q <= 17'h0;
      end else if (dmaAck) begin
         dmaWait_q <= 8'h00;
         xferCnt_q <= xferCnt_q + 17'h1;
      end else if (ctrlTick) begin
         dmaWait_q <= dmaWait_q + 8'h01;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst || cmdWrite) begin
         overrun_q <= 1'b0;
      end else if (dmaReq && ctrlTick && !dmaAck &&
            dmaWait_q >= fdc_support_pkg::DMA_WINDOW_TICKS - 8'd1) begin
         overrun_q <= 1'b1;
      end
   end

   // Result bytes
   always_comb begin
      for (int i = 0; i < fdc_support_pkg::MAX_RESULTS; i++) begin
         results_q[i] = i + 2 < fdc_support_pkg::MAX_CMD_BYTES ?
            cmdBytes_q[i + 2] : 8'h00;
      end
      results_q[0] = 8'h00;
      results_q[0][fdc_support_pkg::ABORT_BIT] = overrun_q;
      results_q[1] = 8'h00;
      results_q[1][fdc_support_pkg::OVERRUN_BIT] = overrun_q;
   end

   // Read data register
   always_ff @(posedge mclk) begin
      if (rst) begin
         ioRdata <= 16'h0000;
         ioRdValid <= 1'b0;
      end else begin
         ioRdValid <= regSel.readStrobe;
         if (regSel.readStrobe && statusHit) begin
            ioRdata <= {8'h00, statusByte};
         end else if (resRead) begin
            ioRdata <= {results_q[byteIdx_q[2:0]], 8'h00};
         end else if (regSel.readStrobe) begin
            ioRdata <= {fdc_support_pkg::IDLE_READ_VALUE, 8'h00};
         end
      end
   end

   // Motor hold timer
   always_ff @(posedge mclk) begin
      if (rst) begin
         holdCnt_q <= 32'h0;
      end else if (resRead && byteIdx_q + 4'h1 >= resLen) begin
         holdCnt_q <= 32'(MOTOR_HOLD_CYCLES);
      end else if (holdCnt_q != 32'h0) begin
         holdCnt_q <= holdCnt_q - 32'h1;
      end
   end
   assign motorOn = holdCnt_q != 32'h0 || dmaReq;

   // Precompensation path
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrSync_q <= 2'h0;
         selSyncA_q <= 2'h0;
         selSyncB_q <= 2'h0;
         shift_q <= 8'h00;
         writeData <= 1'b0;
      end else begin
         wrSync_q <= {wrSync_q[0], writeDataRaw};
         selSyncA_q <= {selSyncA_q[0], preShiftSelLow};
         selSyncB_q <= {selSyncB_q[0], preShiftSelHigh};
         if (masterTick) begin
            shift_q <= {shift_q[6:0], wrSync_q[1]};
         end
         case ({selSyncB_q[1], selSyncA_q[1]})
            2'b00: writeData <= muxIn[0];
            2'b01: writeData <= muxIn[1];
            2'b10: writeData <= muxIn[2];
            default: writeData <= muxIn[3];
         endcase
      end
   end
   // C0 normal, C1 late, C2 early, C3 normal
   assign muxIn = {shift_q[2], shift_q[1], shift_q[3], shift_q[2]};
endmodule
`default_nettype wire

// File: verification/fdc_support_monitor.sv
`default_nettype none
module fdc_support_monitor #(
   parameter longint MOTOR_HOLD_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic rst,
   input wire fdc_support_pkg::io_req_t ioReq,
   input wire logic [15:0] ioRdata,
   input wire logic ioRdValid,
   input wire fdc_support_pkg::reg_sel_t regSel,
   input wire logic dmaReq,
   input wire logic dmaAck,
   input wire logic motorOn,
   input wire logic slowWriteTick,
   input wire logic div16Tap
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [31:0] holdCnt;
   logic [9:0] waitCnt;
   logic inMap;
   logic dataAcc;
   assign dataAcc = ioReq.rd && ioReq.addr == fdc_support_pkg::DATA_ADDR;
   assign inMap = ioReq.addr == fdc_support_pkg::STATUS_ADDR ||
      ioReq.addr == fdc_support_pkg::DATA_ADDR;
   // Cycles of motor on since the last data read, outside DMA
   always_ff @(posedge mclk) begin
      if (rst || !motorOn || dmaReq || dataAcc) holdCnt <= '0;
      else holdCnt <= holdCnt + 32'h1;
   end
   // Cycles of DMA request without service
   always_ff @(posedge mclk) begin
      if (rst || !dmaReq || dmaAck) waitCnt <= '0;
      else waitCnt <= waitCnt + 10'h1;
   end
   sequence statusRead;
      ioReq.rd && ioReq.addr == fdc_support_pkg::STATUS_ADDR;
   endsequence
   sequence dataRead;
      ioReq.rd && ioReq.addr == fdc_support_pkg::DATA_ADDR;
   endsequence
   chk_read_answer: assert property (ioReq.rd && inMap |=> ioRdValid)
      else $error("read not answered");
   chk_valid_cause: assert property (ioRdValid |-> $past(ioReq.rd)
      && $past(inMap)) else $error("stray read valid");
   chk_status_shape: assert property (statusRead |=>
      ioRdata[15:8] == 8'h00 && ioRdata[5] == 1'b0 && ioRdata[3:0] == 4'h0)
      else $error("status word shape wrong");
   chk_data_lane: assert property (dataRead |=> ioRdata[7:0] == 8'h00)
      else $error("data byte on wrong lane");
   chk_select_line: assert property (regSel.registerSelectLine ==
      (ioReq.addr == fdc_support_pkg::DATA_ADDR)) else $error("select wrong");
   chk_strobe_decode: assert property (regSel.writeStrobe ==
      (ioReq.wr && inMap) && regSel.readStrobe == (ioReq.rd && inMap))
      else $error("strobe decode wrong");
   chk_motor_hold: assert property (holdCnt <= MOTOR_HOLD_CYCLES + 2)
      else $error("motor held too long");
   chk_dma_window: assert property (waitCnt <= 10'd330)
      else $error("unserviced DMA not aborted");
   chk_tick_width: assert property ($rose(slowWriteTick) |->
      ##[2:4] !slowWriteTick) else $error("write tick too wide");
   chk_tick_gap: assert property ($fell(slowWriteTick) |=>
      !slowWriteTick [*8]) else $error("write tick too soon");
   chk_div16_half: assert property ($rose(div16Tap) |->
      ##[8:12] $fell(div16Tap)) else $error("div16 half period wrong");
endmodule
bind floppy_ctrl_support_logic fdc_support_monitor #(
   .MOTOR_HOLD_CYCLES(MOTOR_HOLD_CYCLES)
) fdc_support_monitor_inst (.mclk(mclk), .rst(rst), .ioReq(ioReq),
   .ioRdata(ioRdata), .ioRdValid(ioRdValid), .regSel(regSel),
   .dmaReq(dmaReq), .dmaAck(dmaAck), .motorOn(motorOn),
   .slowWriteTick(slowWriteTick), .div16Tap(div16Tap));
`default_nettype wire

// File: verification/proc_model.sv
`default_nettype none
module proc_model (
   input wire logic mclk,
   output fdc_support_pkg::io_req_t ioReq,
   input wire logic [15:0] ioRdata,
   input wire logic ioRdValid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] lastWord;
   logic answered;
   initial ioReq = '0;
   // One access; released lines show the inverse
   task automatic access(input logic rd, input logic [15:0] a,
         input logic [7:0] b);
      @(negedge mclk);
      ioReq <= '{addr: a, rd: rd, wr: !rd, wdata: {b, ~b}};
      @(negedge mclk);
      answered = ioRdValid;
      lastWord = ioRdata;
      ioReq <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: {~b, b}};
   endtask
   // Polls status before any data transfer
   task automatic waitReady(input logic dir, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         access(1'b1, fdc_support_pkg::STATUS_ADDR, 8'h00);
         ok = lastWord[7] === 1'b1 && lastWord[6] === dir;
      end
   endtask
endmodule
`default_nettype wire

// File: verification/floppy_ctrl_support_logic_test.sv
`default_nettype none
module floppy_ctrl_support_logic_test;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [4:0] op; int nCmd; int nRes;} row_t;
   logic mclk = 1'b0, rst = 1'b1, dmaAck = 1'b0, writeDataRaw = 1'b0;
   logic preShiftSelLow = 1'b0, preShiftSelHigh = 1'b0;
   logic ioRdValid, dmaReq, motorOn, writeData, slowWriteTick;
   logic div4Tap, div8Tap, div16Tap, tickQ, div4Q, div8Q, ok;
   logic [15:0] ioRdata;
   logic [7:0] b;
   fdc_support_pkg::io_req_t ioReq;
   fdc_support_pkg::reg_sel_t regSel;
   int failures = 0, checksDone = 0, cycles = 0, ticks = 0, d4 = 0, n;
   int d8 = 0;
   int lat [4];
   row_t rows [5] = '{'{fdc_support_pkg::OP_SPECIFY, 3, 0},
      '{fdc_support_pkg::OP_SEEK, 3, 0}, '{fdc_support_pkg::OP_RECAL, 2, 0},
      '{fdc_support_pkg::OP_SENSE, 1, 2}, '{5'h0a, 1, 1}};
   always #50 mclk = ~mclk;
   floppy_ctrl_support_logic #(.SECTOR_BYTES(4), .MOTOR_HOLD_CYCLES(50))
   floppy_ctrl_support_logic_inst (.mclk(mclk), .rst(rst), .ioReq(ioReq),
      .ioRdata(ioRdata), .ioRdValid(ioRdValid), .regSel(regSel),
      .dmaReq(dmaReq), .dmaAck(dmaAck), .motorOn(motorOn),
      .writeDataRaw(writeDataRaw), .preShiftSelLow(preShiftSelLow),
      .preShiftSelHigh(preShiftSelHigh), .writeData(writeData),
      .slowWriteTick(slowWriteTick), .div4Tap(div4Tap), .div8Tap(div8Tap),
      .div16Tap(div16Tap));
   proc_model proc_model_inst (.mclk(mclk), .ioReq(ioReq),
      .ioRdata(ioRdata), .ioRdValid(ioRdValid));
   always @(posedge mclk) begin
      tickQ <= slowWriteTick;
      div4Q <= div4Tap;
      div8Q <= div8Tap;
      d8 <= d8 + (div8Tap === 1'b1 && div8Q === 1'b0);
      ticks <= ticks + (slowWriteTick === 1'b1 && tickQ === 1'b0);
      d4 <= d4 + (div4Tap === 1'b1 && div4Q === 1'b0);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic status(input logic [7:0] exp);
      proc_model_inst.access(1'b1, fdc_support_pkg::STATUS_ADDR, 8'h00);
      check(proc_model_inst.lastWord[7:0], exp);
      check({7'h00, proc_model_inst.answered}, 8'h01);
   endtask
   task automatic sendCmd(input logic [4:0] op, input int nb);
      for (int k = 0; k < nb; k++) begin
         proc_model_inst.waitReady(1'b0, ok);
         check({7'h00, ok}, 8'h01);
         proc_model_inst.access(1'b0, fdc_support_pkg::DATA_ADDR,
            k == 0 ? {3'h0, op} : 8'(8'h20 + k));
      end
   endtask
   task automatic getResult(output logic [7:0] r);
      proc_model_inst.waitReady(1'b1, ok);
      check({7'h00, ok}, 8'h01);
      proc_model_inst.access(1'b1, fdc_support_pkg::DATA_ADDR, 8'h00);
      r = proc_model_inst.lastWord[15:8];
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      status(8'h80);
      proc_model_inst.access(1'b0, fdc_support_pkg::STATUS_ADDR, 8'h55);
      status(8'h80);
      proc_model_inst.access(1'b1, fdc_support_pkg::DATA_ADDR, 8'h00);
      check(proc_model_inst.lastWord[15:8], 8'hff);
      $display("reset and status done");
      foreach (rows[r]) begin
         sendCmd(rows[r].op, rows[r].nCmd);
         for (int i = 0; i < rows[r].nRes; i++) getResult(b);
         status(8'h80);
         check({7'h00, motorOn}, {7'h00, rows[r].nRes > 0});
         $display("command row %0d done", r);
      end
      sendCmd(fdc_support_pkg::OP_READ, 9);
      status(8'h10);
      check({7'h00, dmaReq}, 8'h01);
      repeat (4) begin
         @(negedge mclk) dmaAck = 1'b1;
         @(negedge mclk) dmaAck = 1'b0;
      end
      getResult(b);
      check({7'h00, b[6]}, 8'h00);
      getResult(b);
      for (int i = 2; i < 7; i++) begin
         getResult(b);
         check(b, 8'(8'h22 + i));
      end
      status(8'h80);
      check({7'h00, motorOn}, 8'h01);
      repeat (60) @(negedge mclk);
      check({7'h00, motorOn}, 8'h00);
      $display("read command done");
      sendCmd(fdc_support_pkg::OP_WRITE, 9);
      for (n = 0; dmaReq === 1'b1 && n < 400; n++) @(negedge mclk);
      check({6'h0, n >= 300, n <= 330}, 8'h03);
      getResult(b);
      check({7'h00, b[6]}, 8'h01);
      getResult(b);
      check({7'h00, b[4]}, 8'h01);
      repeat (5) getResult(b);
      status(8'h80);
      $display("overrun done");
      sendCmd(fdc_support_pkg::OP_READ, 9);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      status(8'h80);
      check({7'h00, dmaReq}, 8'h00);
      $display("reset in exec done");
      for (int s = 0; s < 8; s++) begin
         {preShiftSelHigh, preShiftSelLow, writeDataRaw} = 3'(s);
         repeat (12) @(negedge mclk);
         check({7'h00, writeData}, {7'h00, writeDataRaw});
      end
      // Edge latency per select, aligned to a fixed tap phase
      for (int s = 0; s < 4; s++) begin
         {preShiftSelHigh, preShiftSelLow, writeDataRaw} = {2'(s), 1'b0};
         repeat (12) @(negedge mclk);
         @(posedge div4Tap);
         @(negedge mclk) writeDataRaw = 1'b1;
         for (n = 0; writeData !== 1'b1 && n < 20; n++) @(negedge mclk);
         lat[s] = n;
      end
      check({6'h0, lat[2] < lat[0], lat[0] < lat[1]}, 8'h03);
      check(8'(lat[3]), 8'(lat[0]));
      $display("precompensation done");
      @(negedge mclk) {ticks, d4, d8} = '0;
      repeat (200) @(negedge mclk);
      check(8'(ticks), 8'd10);
      check(8'(d4), 8'd40);
      check(8'(d8), 8'd20);
      $display("write clock done");
      test_done();
   end
endmodule
`default_nettype wire
